// ---- shared/psm_timing_status_defs.vh ----
// Constants for the timing, status and telemetry command bank
`ifndef PSM_TIMING_STATUS_DEFS_VH
`define PSM_TIMING_STATUS_DEFS_VH
// ==========================================
// Command codes
`define CMD_TON_RISE_TIME 8'h61
`define CMD_TON_TIMEOUT_LIMIT 8'h62
`define CMD_TON_TIMEOUT_ACTION 8'h63
`define CMD_TURN_OFF_DELAY_TIME_TIME 8'h64
`define CMD_FAULT_SUMMARY_BYTE 8'h78
`define CMD_FAULT_SUMMARY_WORD 8'h79
`define CMD_OUTPUT_VOLTAGE_FLAGS 8'h7a
`define CMD_OUTPUT_CURRENT_FLAGS 8'h7b
`define CMD_INPUT_SUPPLY_FLAGS 8'h7c
`define CMD_EXT_TEMP_FLAGS 8'h7d
`define CMD_COMM_MEMORY_FLAGS 8'h7e
`define CMD_VENDOR_STATE_FLAGS 8'h80
`define CMD_INPUT_VOLTAGE_READING 8'h88
`define CMD_INPUT_CURRENT_READING 8'h89
`define CMD_OUTPUT_VOLTAGE_READING 8'h8b
`define CMD_OUTPUT_CURRENT_READING 8'h8c
`define CMD_EXT_DIODE_TEMP_READING 8'h8d
`define CMD_DIE_TEMP_READING 8'h8e
`define CMD_OUTPUT_POWER_READING 8'h96
`define CMD_INPUT_POWER_READING 8'h97
`define CMD_PROTOCOL_REVISION 8'h98
`define CMD_GUI_RESERVED_WORD_A 8'hb0
`define CMD_GUI_RESERVED_WORD_B 8'hb1
`define CMD_OEM_RESERVED_WORD 8'hb2
`define CMD_SCRATCHPAD_PAGED 8'hb3
`define CMD_SCRATCHPAD_COMMON 8'hb4
`define CMD_VENDOR_RESERVED_WORD 8'hb5
`define CMD_VENDOR_INFO_WORD 8'hb6
// ==========================================
// Reset values
`define RST_TON_RISE_TIME 16'hd280
`define RST_TON_TIMEOUT_LIMIT 16'hd3c0
`define RST_TON_TIMEOUT_ACTION 8'hb8
`define RST_TURN_OFF_DELAY_TIME_TIME 16'hba00
`define RST_USER_WORD 16'h0000
`define PROTOCOL_REVISION_VAL 8'h11
// ==========================================
// Field positions
`define ACTION_RESP_HI 7
`define ACTION_RESP_LO 6
`define VOUT_FLAG_TON_TIMEOUT 0
`define BYTE_OFF 6
`define BYTE_VOUT_OV 5
`define BYTE_IOUT_OC 4
`define BYTE_VIN_UV 3
`define BYTE_TEMP 2
`define BYTE_CML 1
`define WORD_VOUT 15
`define WORD_IOUT 14
`define WORD_INPUT 13
`define WORD_MFR 12
// ==========================================
// Timing: timer resolution is 1/16 ms
`define CLK_PERIOD_NS 100
`define SUBTICK_NS 62500
`define SUBTICK_CYCLES (`SUBTICK_NS / `CLK_PERIOD_NS)
`define SUBTICK_FRAC_BITS 4
`endif

// ---- design/psm_timing_status.v ----
// Timing, status and telemetry command bank of a four-channel power manager
`timescale 1ns/1ps
`include "psm_timing_status_defs.vh"

module psm_timing_status #(
    parameter NCH = 4,
    parameter [15:0] VENDOR_INFO = 16'h0000, // Arbitrary value
    parameter SUBTICK_CYCLES = `SUBTICK_CYCLES
) (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_clk_en,
    input wire [1:0] i_page,
    input wire i_cmd_wr,
    input wire i_cmd_rd,
    input wire [7:0] i_cmd_code,
    input wire [15:0] i_cmd_wdata,
    output reg [15:0] o_cmd_rdata,
    output reg o_cmd_rvalid,
    output reg o_cmd_err,
    input wire [3:0] i_chan_on,
    input wire [3:0] i_vout_uv,
    input wire [15:0] i_vin,
    input wire [15:0] i_iin,
    input wire [15:0] i_pin,
    input wire [15:0] i_die_temp,
    input wire [63:0] i_vout,
    input wire [63:0] i_iout,
    input wire [63:0] i_ext_temp,
    input wire [63:0] i_pout,
    input wire [31:0] i_vout_flags,
    input wire [31:0] i_iout_flags,
    input wire [31:0] i_temp_flags,
    input wire [31:0] i_mfr_flags,
    input wire [7:0] i_input_flags,
    input wire [7:0] i_cml_flags,
    output reg [3:0] o_channel_output_enable_pin,
    output reg [3:0] o_servo_start,
    output reg [3:0] o_ton_timeout,
    output reg [31:0] o_fault_action,
    output reg [63:0] o_sense_temp
);

    // ==========================================
    // Channel states
    localparam [2:0] ST_OFF = 3'h0;
    localparam [2:0] ST_RISE = 3'h1;
    localparam [2:0] ST_ON = 3'h2;
    localparam [2:0] ST_TOFF = 3'h3;
    localparam [2:0] ST_FAULT = 3'h4;

    // ==========================================
    // Linear-11 milliseconds to 1/16 ms ticks
    function [23:0] l11_ticks;
        input [15:0] v;
        reg signed [5:0] sh;
        reg [5:0] nsh;
        reg [23:0] m;
        begin
            sh = $signed({v[15], v[15:11]}) + 6'sd4;
            nsh = 6'h00 - sh;
            m = v[10] ? 24'h000000 : {14'h0000, v[9:0]};
            if (sh[5]) begin
                l11_ticks = m >> nsh;
            end else if (sh > 6'sd13) begin
                l11_ticks = 24'hffffff;
            end else begin
                l11_ticks = m << sh[4:0];
            end
        end
    endfunction

    // ==========================================
    // Synchronisers and sub-millisecond tick
    reg [3:0] on_meta;
    reg [3:0] on_s;
    reg [15:0] pre_cnt;
    reg tick;

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            on_meta <= 4'h0;
            on_s <= 4'h0;
            pre_cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (i_clk_en) begin
            on_meta <= i_chan_on;
            on_s <= on_meta;
            if (pre_cnt >= SUBTICK_CYCLES[15:0] - 16'h0001) begin
                pre_cnt <= 16'h0000;
                tick <= 1'b1;
            end else begin
                pre_cnt <= pre_cnt + 16'h0001;
                tick <= 1'b0;
            end
        end
    end

    // ==========================================
    // Command storage
    reg [15:0] rise_t [0:3];
    reg [15:0] tmo_lim [0:3];
    reg [7:0] tmo_act [0:3];
    reg [15:0] toff_t [0:3];
    reg [15:0] gui_b [0:3];
    reg [15:0] scratch_p [0:3];
    reg [15:0] vend_res [0:3];
    reg [15:0] gui_a;
    reg [15:0] oem_word;
    reg [15:0] scratch_c;
    integer k;
    integer j;

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            for (j = 0; j < NCH; j = j + 1) begin
                rise_t[j] <= `RST_TON_RISE_TIME;
                tmo_lim[j] <= `RST_TON_TIMEOUT_LIMIT;
                tmo_act[j] <= `RST_TON_TIMEOUT_ACTION;
                toff_t[j] <= `RST_TURN_OFF_DELAY_TIME_TIME;
                gui_b[j] <= `RST_USER_WORD;
                scratch_p[j] <= `RST_USER_WORD;
                vend_res[j] <= `RST_USER_WORD;
            end
            gui_a <= `RST_USER_WORD;
            oem_word <= `RST_USER_WORD;
            scratch_c <= `RST_USER_WORD;
        end else if (i_clk_en && i_cmd_wr) begin
            case (i_cmd_code)
                `CMD_TON_RISE_TIME: rise_t[i_page] <= i_cmd_wdata;
                `CMD_TON_TIMEOUT_LIMIT: tmo_lim[i_page] <= i_cmd_wdata;
                `CMD_TON_TIMEOUT_ACTION: tmo_act[i_page] <= i_cmd_wdata[7:0];
                `CMD_TURN_OFF_DELAY_TIME_TIME: toff_t[i_page] <= i_cmd_wdata;
                `CMD_GUI_RESERVED_WORD_B: gui_b[i_page] <= i_cmd_wdata;
                `CMD_SCRATCHPAD_PAGED: scratch_p[i_page] <= i_cmd_wdata;
                `CMD_VENDOR_RESERVED_WORD: vend_res[i_page] <= i_cmd_wdata;
                `CMD_GUI_RESERVED_WORD_A: gui_a <= i_cmd_wdata;
                `CMD_OEM_RESERVED_WORD: oem_word <= i_cmd_wdata;
                `CMD_SCRATCHPAD_COMMON: scratch_c <= i_cmd_wdata;
                default: ;
            endcase
        end
    end

    // ==========================================
    // Channel sequencing and turn-on supervision
    reg [2:0] st [0:3];
    reg [23:0] tmr [0:3];
    reg [23:0] tmo [0:3];
    reg [3:0] watch;
    reg [3:0] ton_sticky;
    wire [23:0] rise_ticks [0:3];
    wire [23:0] tmo_ticks [0:3];
    wire [23:0] toff_ticks [0:3];
    wire [3:0] act_off;
    wire [3:0] ton_expired;
    genvar g;

    // Programmed times in sub-millisecond ticks
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ticks
            assign rise_ticks[g] = l11_ticks(rise_t[g]);
            assign tmo_ticks[g] = l11_ticks(tmo_lim[g]);
            assign toff_ticks[g] = l11_ticks(toff_t[g]);
            assign act_off[g] = tmo_act[g][`ACTION_RESP_HI:`ACTION_RESP_LO] != 2'b00;
            assign ton_expired[g] = watch[g] && i_vout_uv[g] && st[g] != ST_OFF && st[g] != ST_FAULT &&
                tmo[g] >= tmo_ticks[g];
        end
    endgenerate

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            for (k = 0; k < NCH; k = k + 1) begin
                st[k] <= ST_OFF;
                tmr[k] <= 24'h000000;
                tmo[k] <= 24'h000000;
            end
            watch <= 4'h0;
            ton_sticky <= 4'h0;
            o_channel_output_enable_pin <= 4'h0;
            o_servo_start <= 4'h0;
            o_ton_timeout <= 4'h0;
            o_fault_action <= 32'h00000000;
            o_sense_temp <= 64'h0;
        end else if (i_clk_en) begin
            o_sense_temp <= i_ext_temp;
            for (k = 0; k < NCH; k = k + 1) begin
                o_ton_timeout[k] <= 1'b0;
                if (tick && tmr[k] != 24'hffffff) begin
                    tmr[k] <= tmr[k] + 24'h000001;
                end
                if (tick && tmo[k] != 24'hffffff) begin
                    tmo[k] <= tmo[k] + 24'h000001;
                end
                if (watch[k] && !i_vout_uv[k]) begin
                    watch[k] <= 1'b0;
                end
                case (st[k])
                    ST_OFF: begin
                        if (on_s[k]) begin
                            o_channel_output_enable_pin[k] <= 1'b1;
                            tmr[k] <= 24'h000000;
                            tmo[k] <= 24'h000000;
                            watch[k] <= 1'b1;
                            ton_sticky[k] <= 1'b0;
                            st[k] <= ST_RISE;
                        end
                    end
                    ST_RISE: begin
                        if (!on_s[k]) begin
                            tmr[k] <= 24'h000000;
                            st[k] <= ST_TOFF;
                        end else if (tmr[k] >= rise_ticks[k]) begin
                            o_servo_start[k] <= 1'b1;
                            st[k] <= ST_ON;
                        end
                    end
                    ST_ON: begin
                        if (!on_s[k]) begin
                            tmr[k] <= 24'h000000;
                            st[k] <= ST_TOFF;
                        end
                    end
                    ST_TOFF: begin
                        o_servo_start[k] <= 1'b0;
                        if (on_s[k]) begin
                            tmr[k] <= 24'h000000;
                            st[k] <= ST_RISE;
                        end else if (tmr[k] >= toff_ticks[k]) begin
                            o_channel_output_enable_pin[k] <= 1'b0;
                            watch[k] <= 1'b0;
                            st[k] <= ST_OFF;
                        end
                    end
                    ST_FAULT: begin
                        o_channel_output_enable_pin[k] <= 1'b0;
                        o_servo_start[k] <= 1'b0;
                        if (!on_s[k]) begin
                            st[k] <= ST_OFF;
                        end
                    end
                    default: st[k] <= ST_OFF;
                endcase
                if (ton_expired[k]) begin
                    watch[k] <= 1'b0;
                    ton_sticky[k] <= 1'b1;
                    o_ton_timeout[k] <= 1'b1;
                    o_fault_action[k*8 +: 8] <= tmo_act[k];
                    if (act_off[k]) begin
                        o_channel_output_enable_pin[k] <= 1'b0;
                        o_servo_start[k] <= 1'b0;
                        st[k] <= ST_FAULT;
                    end
                end
            end
        end
    end

    // ==========================================
    // Status composition for the selected page
    reg [7:0] vflags;
    reg [7:0] iflags;
    reg [7:0] tflags;
    reg [7:0] mflags;
    reg [7:0] sum_byte;
    reg [15:0] sum_word;

    always @* begin
        vflags = i_vout_flags[i_page*8 +: 8];
        vflags[`VOUT_FLAG_TON_TIMEOUT] = vflags[`VOUT_FLAG_TON_TIMEOUT] | ton_sticky[i_page];
        iflags = i_iout_flags[i_page*8 +: 8];
        tflags = i_temp_flags[i_page*8 +: 8];
        mflags = i_mfr_flags[i_page*8 +: 8];
        sum_byte = 8'h00;
        sum_byte[`BYTE_OFF] = ~o_channel_output_enable_pin[i_page];
        sum_byte[`BYTE_VOUT_OV] = vflags[7];
        sum_byte[`BYTE_IOUT_OC] = iflags[7];
        sum_byte[`BYTE_VIN_UV] = i_input_flags[4];
        sum_byte[`BYTE_TEMP] = |tflags;
        sum_byte[`BYTE_CML] = |i_cml_flags;
        sum_word = {8'h00, sum_byte};
        sum_word[`WORD_VOUT] = |vflags;
        sum_word[`WORD_IOUT] = |iflags;
        sum_word[`WORD_INPUT] = |i_input_flags;
        sum_word[`WORD_MFR] = |mflags;
    end

    // ==========================================
    // Read port
    reg [15:0] next_rdata;
    reg next_err;

    always @* begin
        next_rdata = 16'h0000;
        next_err = 1'b0;
        case (i_cmd_code)
            `CMD_TON_RISE_TIME: next_rdata = rise_t[i_page];
            `CMD_TON_TIMEOUT_LIMIT: next_rdata = tmo_lim[i_page];
            `CMD_TON_TIMEOUT_ACTION: next_rdata = {8'h00, tmo_act[i_page]};
            `CMD_TURN_OFF_DELAY_TIME_TIME: next_rdata = toff_t[i_page];
            `CMD_FAULT_SUMMARY_BYTE: next_rdata = {8'h00, sum_byte};
            `CMD_FAULT_SUMMARY_WORD: next_rdata = sum_word;
            `CMD_OUTPUT_VOLTAGE_FLAGS: next_rdata = {8'h00, vflags};
            `CMD_OUTPUT_CURRENT_FLAGS: next_rdata = {8'h00, iflags};
            `CMD_INPUT_SUPPLY_FLAGS: next_rdata = {8'h00, i_input_flags};
            `CMD_EXT_TEMP_FLAGS: next_rdata = {8'h00, tflags};
            `CMD_COMM_MEMORY_FLAGS: next_rdata = {8'h00, i_cml_flags};
            `CMD_VENDOR_STATE_FLAGS: next_rdata = {8'h00, mflags};
            `CMD_INPUT_VOLTAGE_READING: next_rdata = i_vin;
            `CMD_INPUT_CURRENT_READING: next_rdata = i_iin;
            `CMD_OUTPUT_VOLTAGE_READING: next_rdata = i_vout[i_page*16 +: 16];
            `CMD_OUTPUT_CURRENT_READING: next_rdata = i_iout[i_page*16 +: 16];
            `CMD_EXT_DIODE_TEMP_READING: next_rdata = o_sense_temp[i_page*16 +: 16];
            `CMD_DIE_TEMP_READING: next_rdata = i_die_temp;
            `CMD_OUTPUT_POWER_READING: next_rdata = i_pout[i_page*16 +: 16];
            `CMD_INPUT_POWER_READING: next_rdata = i_pin;
            `CMD_PROTOCOL_REVISION: next_rdata = {8'h00, `PROTOCOL_REVISION_VAL};
            `CMD_GUI_RESERVED_WORD_A: next_rdata = gui_a;
            `CMD_GUI_RESERVED_WORD_B: next_rdata = gui_b[i_page];
            `CMD_OEM_RESERVED_WORD: next_rdata = oem_word;
            `CMD_SCRATCHPAD_PAGED: next_rdata = scratch_p[i_page];
            `CMD_SCRATCHPAD_COMMON: next_rdata = scratch_c;
            `CMD_VENDOR_RESERVED_WORD: next_rdata = vend_res[i_page];
            `CMD_VENDOR_INFO_WORD: next_rdata = VENDOR_INFO;
            default: next_err = 1'b1;
        endcase
    end

    // ==========================================
    // Writes to read-only or unknown codes are flagged
    reg wr_ok;

    always @* begin
        case (i_cmd_code)
            `CMD_TON_RISE_TIME, `CMD_TON_TIMEOUT_LIMIT, `CMD_TON_TIMEOUT_ACTION,
            `CMD_TURN_OFF_DELAY_TIME_TIME, `CMD_GUI_RESERVED_WORD_A, `CMD_GUI_RESERVED_WORD_B,
            `CMD_OEM_RESERVED_WORD, `CMD_SCRATCHPAD_PAGED, `CMD_SCRATCHPAD_COMMON,
            `CMD_VENDOR_RESERVED_WORD: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // ==========================================
    // Command response
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cmd_rdata <= 16'h0000;
            o_cmd_rvalid <= 1'b0;
            o_cmd_err <= 1'b0;
        end else if (i_clk_en) begin
            o_cmd_rvalid <= i_cmd_rd & ~next_err;
            o_cmd_err <= (i_cmd_rd & next_err) | (i_cmd_wr & ~wr_ok);
            if (i_cmd_rd) begin
                o_cmd_rdata <= next_err ? 16'h0000 : next_rdata;
            end
        end
    end

endmodule

// ---- tb/psm_supply_model.sv ----
// Supply and sensor model facing the command bank
`timescale 1ns/1ps
module psm_supply_model (
    input wire [3:0] i_enable,
    input wire [3:0] i_servo,
    input wire [3:0] i_stuck_low,
    output wire [3:0] o_vout_uv,
    output wire [15:0] o_vin,
    output wire [15:0] o_iin,
    output wire [15:0] o_pin,
    output wire [15:0] o_die_temp,
    output wire [63:0] o_vout,
    output wire [63:0] o_iout,
    output wire [63:0] o_ext_temp,
    output wire [63:0] o_pout,
    output wire [7:0] o_input_flags,
    output wire [7:0] o_cml_flags
);
    // ==========================================
    // Output sags until servo starts, or for good when stuck
    assign o_vout_uv = i_enable & (~i_servo | i_stuck_low);
    // ==========================================
    // Sensor words; input and die words shared, per-channel words distinct per channel
    assign o_vin = 16'hd2c0;
    assign o_iin = 16'hc3a0;
    assign o_pin = 16'hd140;
    assign o_die_temp = 16'he190;
    assign o_vout = 64'h1a03_1a02_1a01_1a00;
    assign o_iout = 64'hd103_d102_d101_d100;
    assign o_ext_temp = 64'he003_e002_e001_e000;
    assign o_pout = 64'hc803_c802_c801_c800;
    assign o_input_flags = 8'h21;
    assign o_cml_flags = 8'h02;
endmodule

// ---- tb/psm_timing_status_monitor.sv ----
// Assertion checker for the timing and status command bank
`timescale 1ns/1ps
module psm_timing_status_monitor #(
    parameter SUBTICK_CYCLES = 625
) (
    input wire i_ref_clk,
    input wire i_rst,
    input wire [1:0] i_page,
    input wire i_cmd_wr,
    input wire i_cmd_rd,
    input wire [7:0] i_cmd_code,
    input wire [15:0] o_cmd_rdata,
    input wire o_cmd_rvalid,
    input wire o_cmd_err,
    input wire [3:0] i_chan_on,
    input wire [3:0] i_vout_uv,
    input wire [15:0] i_iin,
    input wire [63:0] i_vout,
    input wire [7:0] i_input_flags,
    input wire [7:0] i_cml_flags,
    input wire [3:0] o_channel_output_enable_pin,
    input wire [3:0] o_servo_start,
    input wire [3:0] o_ton_timeout,
    input wire [31:0] o_fault_action,
    input wire [63:0] o_sense_temp
);
    localparam int TOFF_LO = 16 * SUBTICK_CYCLES;
    localparam int TOFF_HI = TOFF_LO + 8;
    int off_cnt;
    // ==========================================
    // Cycles with channel 1 commanded off but still enabled
    always @(posedge i_ref_clk) begin
        if (i_rst || i_chan_on[1] || !o_channel_output_enable_pin[1]) begin
            off_cnt <= 0;
        end else begin
            off_cnt <= off_cnt + 1;
        end
    end
    // ==========================================
    // Properties
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_rd(c); i_cmd_rd && i_cmd_code == c; endsequence
    property p_ro_wr; i_cmd_wr && i_cmd_code == 8'h78 |=> o_cmd_err && !o_cmd_rvalid; endproperty
    a_ro_wr: assert property (p_ro_wr) else $error("write to status byte not refused");
    property p_rev; s_rd(8'h98) |=> o_cmd_rvalid && o_cmd_rdata == 16'h0011; endproperty
    a_rev: assert property (p_rev) else $error("revision read wrong");
    property p_input; s_rd(8'h7c) |=> o_cmd_rdata == {8'h00, $past(i_input_flags)}; endproperty
    a_input: assert property (p_input) else $error("input flags read wrong");
    property p_cml; s_rd(8'h7e) |=> o_cmd_rdata == {8'h00, $past(i_cml_flags)}; endproperty
    a_cml: assert property (p_cml) else $error("comm flags read wrong");
    property p_iin; s_rd(8'h89) |=> o_cmd_rdata == $past(i_iin); endproperty
    a_iin: assert property (p_iin) else $error("input current read wrong");
    property p_vout; s_rd(8'h8b) |=> o_cmd_rdata == $past(i_vout[i_page*16 +: 16]); endproperty
    a_vout: assert property (p_vout) else $error("output voltage read wrong");
    property p_temp; s_rd(8'h8d) |=> o_cmd_rdata == $past(o_sense_temp[i_page*16 +: 16]); endproperty
    a_temp: assert property (p_temp) else $error("diode temperature read wrong");
    property p_rise; $rose(o_servo_start[0]) |-> $past(o_channel_output_enable_pin[0], 300); endproperty
    a_rise: assert property (p_rise) else $error("servo started early");
    property p_tmo; o_ton_timeout[0] |-> $past(o_channel_output_enable_pin[0], 300) && $past(i_vout_uv[0]); endproperty
    a_tmo: assert property (p_tmo) else $error("timeout without long undervoltage");
    property p_act; o_ton_timeout[0] |-> ##[0:2] (o_fault_action[7:0] == 8'hb8 && !o_channel_output_enable_pin[0]);
    endproperty
    a_act: assert property (p_act) else $error("default timeout action not applied");
    property p_toff; $fell(o_channel_output_enable_pin[1]) && !i_chan_on[1] |->
        off_cnt >= TOFF_LO && off_cnt <= TOFF_HI; endproperty
    a_toff: assert property (p_toff) else $error("turn-off delay wrong");
    c_rd: cover property (o_cmd_rvalid);
    c_tmo: cover property (o_ton_timeout[0]);
    c_off: cover property ($fell(o_channel_output_enable_pin[1]));
endmodule

bind psm_timing_status psm_timing_status_monitor #(.SUBTICK_CYCLES(SUBTICK_CYCLES)) i_mon (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_page(i_page), .i_cmd_wr(i_cmd_wr), .i_cmd_rd(i_cmd_rd),
    .i_cmd_code(i_cmd_code), .o_cmd_rdata(o_cmd_rdata), .o_cmd_rvalid(o_cmd_rvalid), .o_cmd_err(o_cmd_err),
    .i_chan_on(i_chan_on), .i_vout_uv(i_vout_uv), .i_iin(i_iin), .i_vout(i_vout),
    .i_input_flags(i_input_flags), .i_cml_flags(i_cml_flags), .o_fault_action(o_fault_action),
    .o_channel_output_enable_pin(o_channel_output_enable_pin), .o_servo_start(o_servo_start),
    .o_ton_timeout(o_ton_timeout), .o_sense_temp(o_sense_temp)
);

// ---- tb/psm_timing_status_tb.sv ----
// Self-checking bench for the timing, status and telemetry command bank
`timescale 1ns/1ps
module psm_timing_status_tb;
    localparam SUB = 2;
    localparam [47:0] RC = {8'h61, 8'h62, 8'h63, 8'h64, 8'h98, 8'hb3};
    localparam [95:0] RV = {16'hd280, 16'hd3c0, 16'h00b8, 16'hba00, 16'h0011, 16'h0000};
    localparam [63:0] RO = {8'h78, 8'h79, 8'h7c, 8'h7e, 8'h89, 8'h8b, 8'h96, 8'h98};
    reg i_ref_clk = 1'b0;
    reg i_rst = 1'b1;
    reg [1:0] page = 2'h0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [7:0] code = 8'h00;
    reg [15:0] wdata = 16'h0000;
    reg [3:0] on = 4'h0;
    reg [3:0] stuck = 4'h0;
    wire [15:0] rdata, vin, iin, pin, die;
    wire rvalid, err;
    wire [3:0] uv, en, servo, tmo;
    wire [63:0] vout, iout, etemp, pout;
    wire [7:0] inflg, cml;
    integer fails = 0;
    integer total_checks = 0;
    integer i, n;
    always #50 i_ref_clk = ~i_ref_clk;
    psm_timing_status #(.SUBTICK_CYCLES(SUB)) i_dut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_clk_en(1'b1), .i_page(page), .i_cmd_wr(wr), .i_cmd_rd(rd),
        .i_cmd_code(code), .i_cmd_wdata(wdata), .o_cmd_rdata(rdata), .o_cmd_rvalid(rvalid), .o_cmd_err(err),
        .i_chan_on(on), .i_vout_uv(uv), .i_vin(vin), .i_iin(iin), .i_pin(pin), .i_die_temp(die), .i_vout(vout),
        .i_iout(iout), .i_ext_temp(etemp), .i_pout(pout), .i_vout_flags(32'h0), .i_iout_flags(32'h0),
        .i_temp_flags(32'h0), .i_mfr_flags(32'h0), .i_input_flags(inflg), .i_cml_flags(cml),
        .o_channel_output_enable_pin(en), .o_servo_start(servo), .o_ton_timeout(tmo), .o_fault_action(),
        .o_sense_temp()
    );
    psm_supply_model i_sup (
        .i_enable(en), .i_servo(servo), .i_stuck_low(stuck), .o_vout_uv(uv), .o_vin(vin), .o_iin(iin),
        .o_pin(pin), .o_die_temp(die), .o_vout(vout), .o_iout(iout), .o_ext_temp(etemp), .o_pout(pout),
        .o_input_flags(inflg), .o_cml_flags(cml)
    );
    // ==========================================
    // Tasks
    task check(input string name, input [15:0] got, input [15:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr_cmd(input [7:0] c, input [15:0] d, input bad);
        @(negedge i_ref_clk);
        wr = 1'b1;
        code = c;
        wdata = d;
        @(negedge i_ref_clk);
        wr = 1'b0;
        check("write error", {15'h0, err}, {15'h0, bad});
    endtask
    task rd_cmd(input [7:0] c, input [15:0] e, input bad);
        @(negedge i_ref_clk);
        rd = 1'b1;
        code = c;
        @(negedge i_ref_clk);
        rd = 1'b0;
        check("read answer", {14'h0, rvalid, err}, {14'h0, !bad, bad});
        if (!bad)
            check("read data", rdata, e);
    endtask
    task wait_on(input integer sel, input integer ch, input v);
        n = 0;
        while ((sel == 0 ? en[ch] : sel == 1 ? servo[ch] : tmo[ch]) !== v && n < 2000)
            @(negedge i_ref_clk) n = n + 1;
        check("wait limit", {15'h0, n < 2000}, 16'h0001);
    endtask
    task results;
        if (fails == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        repeat (6) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_rst = 1'b0;
        for (i = 0; i < 6; i = i + 1)
            rd_cmd(RC[8*i +: 8], RV[16*i +: 16], 1'b0);
        for (i = 0; i < 8; i = i + 1)
            wr_cmd(RO[8*i +: 8], 16'h00ff, 1'b1);
        rd_cmd(8'h98, 16'h0011, 1'b0);
        rd_cmd(8'h65, 16'h0000, 1'b1);
        page = 2'h1;
        wr_cmd(8'hb3, 16'h1234, 1'b0);
        page = 2'h2;
        wr_cmd(8'hb4, 16'habcd, 1'b0);
        page = 2'h3;
        rd_cmd(8'hb3, 16'h0000, 1'b0);
        rd_cmd(8'hb4, 16'habcd, 1'b0);
        for (i = 0; i < 4; i = i + 1) begin
            page = i[1:0];
            rd_cmd(8'h8b, 16'h1a00 + i[15:0], 1'b0);
            rd_cmd(8'h96, 16'hc800 + i[15:0], 1'b0);
            rd_cmd(8'h8d, 16'he000 + i[15:0], 1'b0);
            rd_cmd(8'h89, 16'hc3a0, 1'b0);
            rd_cmd(8'h7c, 16'h0021, 1'b0);
            rd_cmd(8'h7e, 16'h0002, 1'b0);
        end
        page = 2'h1;
        rd_cmd(8'hb3, 16'h1234, 1'b0);
        wr_cmd(8'h61, 16'hd080, 1'b0);
        on[1] = 1'b1;
        wait_on(0, 1, 1'b1);
        wait_on(1, 1, 1'b1);
        check("rise time", {15'h0, n >= 30 * SUB && n <= 36 * SUB}, 16'h0001);
        @(negedge i_ref_clk);
        on[1] = 1'b0;
        wait_on(0, 1, 1'b0);
        check("off delay", {15'h0, n >= 16 * SUB && n <= 20 * SUB}, 16'h0001);
        page = 2'h2;
        wr_cmd(8'h63, 16'h0000, 1'b0);
        stuck = 4'h5;
        on = 4'h5;
        wait_on(2, 0, 1'b1);
        check("timeout", {15'h0, n >= 240 * SUB && n <= 246 * SUB}, 16'h0001);
        repeat (3) @(negedge i_ref_clk);
        check("fault off", {15'h0, en[0]}, 16'h0000);
        check("continue", {15'h0, en[2]}, 16'h0001);
        rd_cmd(8'h78, 16'h0002, 1'b0);
        page = 2'h0;
        rd_cmd(8'h7a, 16'h0001, 1'b0);
        rd_cmd(8'h78, 16'h0042, 1'b0);
        rd_cmd(8'h79, 16'ha042, 1'b0);
        results;
    end
    initial begin
        #(20000 * 100);
        fails = fails + 1;
        results;
    end
endmodule
